// [rtl/ssm_pkg.sv]
// constants and types of the serial port status and state monitor
package ssm_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [23:0] IDX_STATUS   = 24'hFFE264;
  localparam logic [23:0] IDX_STATE    = 24'hFFE265;
  localparam logic [23:0] IDX_CTRL     = 24'hFFE270;
  localparam logic [23:0] IDX_IRQ_STAT = 24'hFFE271;
  localparam logic [23:0] IDX_IRQ_EN   = 24'hFFE272;
  localparam logic [23:0] IDX_IRQ_CLR  = 24'hFFE273;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned ST_TX_EMPTY = 7;
  localparam int unsigned ST_UNDERRUN = 6;
  localparam int unsigned ST_COLLIDE  = 5;
  localparam int unsigned ST_ABORT    = 4;
  localparam int unsigned ST_OVERRUN  = 3;
  localparam int unsigned ST_RX_FULL  = 2;
  localparam int unsigned ST_ACTIVE   = 1;
  localparam int unsigned ST_SELECT   = 0;
  localparam logic [7:0]  STATUS_RST  = 8'h01;
  localparam logic [7:0]  STATE_RST   = 8'h00;

  localparam int unsigned CTL_ENABLE = 0;
  localparam int unsigned CTL_MASTER = 1;
  localparam int unsigned CTL_POL    = 2;
  localparam int unsigned CTL_RGC    = 3;
  localparam int unsigned CTL_I2S    = 4;
  localparam int unsigned CTL_SS_OUT = 5;
  localparam int unsigned CTL_LEN_LO = 6;
  localparam int unsigned CTL_LEN_HI = 8;

  localparam int unsigned IRQ_W        = 6;
  localparam int unsigned IRQ_UNDERRUN = 0;
  localparam int unsigned IRQ_COLLIDE  = 1;
  localparam int unsigned IRQ_ABORT    = 2;
  localparam int unsigned IRQ_OVERRUN  = 3;
  localparam int unsigned IRQ_RX_LOAD  = 4;
  localparam int unsigned IRQ_TX_TAKEN = 5;

  // ---------------------------------------------------------------
  // transfer state codes
  // ---------------------------------------------------------------
  localparam logic [5:0] CODE_IDLE    = 6'h00;
  localparam logic [5:0] CODE_SWAIT   = 6'h01;
  localparam logic [5:0] CODE_I2SS1   = 6'h02;
  localparam logic [5:0] CODE_I2SS2   = 6'h03;
  localparam logic [5:0] CODE_MSTART  = 6'h10;
  localparam logic [5:0] CODE_I2SM1   = 6'h31;
  localparam logic [5:0] CODE_I2SM2   = 6'h32;
  localparam logic [1:0] CODE_SHIFT_H = 2'h2;

  typedef enum logic [2:0] {
    SSM_IDLE, SSM_SWAIT, SSM_I2SS1, SSM_I2SS2,
    SSM_MSTART, SSM_I2SM1, SSM_I2SM2, SSM_SHIFT
  } ssm_fsm_t;

  // packed from bit 8 down, so the struct reads back as the control word
  typedef struct packed {
    logic [2:0] charLength;
    logic       selectIsOutput;
    logic       i2sMode;
    logic       rateGenControl;
    logic       selectPolarity;
    logic       masterEnable;
    logic       portEnable;
  } ssm_ctrl_t;

  typedef struct packed {
    logic [2:0]       sckSh;
    logic [2:0]       ssSh;
    logic [2:0]       mosiSh;
    logic [2:0]       misoSh;
    logic             sckF;
    logic             ssF;
    logic             mosiF;
    logic             misoF;
    logic             sckPrev;
    logic             ssPrev;
    ssm_ctrl_t        ctrl;
    ssm_fsm_t         state;
    logic [2:0]       bitIdx;
    logic             phaseTx;
    logic             txHeld;
    logic             txEmptyFlag;
    logic             underrun;
    logic             collision;
    logic             abort;
    logic             overrun;
    logic             rxFull;
    logic             transferActive;
    logic             selectLevel;
    logic             clockPinLevel;
    logic             dataInLevel;
    logic [5:0]       stateCode;
    logic [IRQ_W-1:0] irqStatus;
    logic [IRQ_W-1:0] irqEnable;
    logic             irq;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } ssm_regs_t;

endpackage

// [rtl/ssm_top.sv]
// serial port status flags, pin observation and transfer state monitor
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module ssm_top
  import ssm_pkg::*;
(
  input  wire logic        mclk,        // system clock, 250 MHz
  input  wire logic        sys_rst,     // synchronous reset, high
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb direction
  input  wire logic [31:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error, unmapped address
  input  wire logic        sckPin,      // serial clock pin
  input  wire logic        mosiPin,     // master-out data pin
  input  wire logic        misoPin,     // master-in data pin
  input  wire logic        ssPin,       // slave select pin
  input  wire logic        txDataWrite, // software wrote tx data
  input  wire logic        rxDataRead,  // software read rx data
  input  wire logic        sckTimeout,  // clock monitor time-out pulse
  output logic             irq          // level interrupt
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic regHit(input logic [31:0] a,
                                  input logic [23:0] idx);
    return a == {6'h00, idx, 2'h0};
  endfunction

  function automatic logic [5:0] codeOf(input ssm_fsm_t s,
                                        input logic [2:0] idx,
                                        input logic tx);
    case (s)
      SSM_IDLE:   codeOf = CODE_IDLE;
      SSM_SWAIT:  codeOf = CODE_SWAIT;
      SSM_I2SS1:  codeOf = CODE_I2SS1;
      SSM_I2SS2:  codeOf = CODE_I2SS2;
      SSM_MSTART: codeOf = CODE_MSTART;
      SSM_I2SM1:  codeOf = CODE_I2SM1;
      SSM_I2SM2:  codeOf = CODE_I2SM2;
      SSM_SHIFT:  codeOf = {CODE_SHIFT_H, idx, tx};
      default:    codeOf = CODE_IDLE;
    endcase
  endfunction

  // char length 000 means 8 bits, so first index wraps to 7
  function automatic logic [2:0] firstBit(input logic [2:0] len);
    return 3'(len - 3'h1);
  endfunction

  ssm_regs_t r;
  ssm_regs_t n;

  logic             sckRise;
  logic             sckFall;
  logic             ssAsserted;
  logic             access;
  logic             wrCommit;
  logic             hitStatus;
  logic             hitState;
  logic             hitCtrl;
  logic             hitIrqStat;
  logic             hitIrqEn;
  logic             hitIrqClr;
  logic             takeTx;
  logic             evUnderrun;
  logic             evCollision;
  logic             evAbort;
  logic             evOverrun;
  logic             evRxLoad;
  logic [7:0]       statusWord;
  logic [7:0]       stateWord;
  logic [IRQ_W-1:0] events;

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign irq     = r.irq;

  always_comb begin
    n           = r;
    takeTx      = 1'b0;
    evUnderrun  = 1'b0;
    evCollision = 1'b0;
    evAbort     = 1'b0;
    evOverrun   = 1'b0;
    evRxLoad    = 1'b0;

    // -------------------------------------------------------------
    // pin synchronisers: a change counts once stages two and three agree
    // -------------------------------------------------------------
    n.sckSh  = {r.sckSh[1:0], sckPin};
    n.ssSh   = {r.ssSh[1:0], ssPin};
    n.mosiSh = {r.mosiSh[1:0], mosiPin};
    n.misoSh = {r.misoSh[1:0], misoPin};
    if (r.sckSh[2] == r.sckSh[1]) n.sckF = r.sckSh[1];
    if (r.ssSh[2] == r.ssSh[1]) n.ssF = r.ssSh[1];
    if (r.mosiSh[2] == r.mosiSh[1]) n.mosiF = r.mosiSh[1];
    if (r.misoSh[2] == r.misoSh[1]) n.misoF = r.misoSh[1];
    n.sckPrev  = r.sckF;
    n.ssPrev   = r.ssF;
    sckRise    = r.sckF & ~r.sckPrev;
    sckFall    = ~r.sckF & r.sckPrev;
    ssAsserted = ~(r.ssF ^ r.ctrl.selectPolarity);

    // -------------------------------------------------------------
    // apb slave: one wait state, write commits when pready is seen
    // -------------------------------------------------------------
    access     = psel & penable;
    wrCommit   = access & r.pready & pwrite;
    hitStatus  = regHit(paddr, IDX_STATUS);
    hitState   = regHit(paddr, IDX_STATE);
    hitCtrl    = regHit(paddr, IDX_CTRL);
    hitIrqStat = regHit(paddr, IDX_IRQ_STAT);
    hitIrqEn   = regHit(paddr, IDX_IRQ_EN);
    hitIrqClr  = regHit(paddr, IDX_IRQ_CLR);
    statusWord = {r.txEmptyFlag, r.underrun, r.collision, r.abort,
                  r.overrun, r.rxFull, r.transferActive, r.selectLevel};
    stateWord  = {r.clockPinLevel, r.dataInLevel, r.stateCode};
    n.pready   = access & ~r.pready;
    n.pslverr  = access & ~r.pready & ~(hitStatus | hitState | hitCtrl |
                 hitIrqStat | hitIrqEn | hitIrqClr);
    if (access & ~r.pready) begin
      n.prdata = 32'h0000_0000;
      if (hitStatus) n.prdata[7:0] = statusWord;
      if (hitState) n.prdata[7:0] = stateWord;
      if (hitCtrl) n.prdata[8:0] = r.ctrl;
      if (hitIrqStat) n.prdata[IRQ_W-1:0] = r.irqStatus;
      if (hitIrqEn) n.prdata[IRQ_W-1:0] = r.irqEnable;
    end
    if (wrCommit & hitCtrl) begin
      n.ctrl.portEnable     = pwdata[CTL_ENABLE];
      n.ctrl.masterEnable   = pwdata[CTL_MASTER];
      n.ctrl.selectPolarity = pwdata[CTL_POL];
      n.ctrl.rateGenControl = pwdata[CTL_RGC];
      n.ctrl.i2sMode        = pwdata[CTL_I2S];
      n.ctrl.selectIsOutput = pwdata[CTL_SS_OUT];
      n.ctrl.charLength     = pwdata[CTL_LEN_HI:CTL_LEN_LO];
    end
    if (wrCommit & hitIrqEn) n.irqEnable = pwdata[IRQ_W-1:0];

    // -------------------------------------------------------------
    // transfer state machine, driven by sampled clock edges
    // -------------------------------------------------------------
    case (r.state)
      SSM_IDLE: begin
        if (r.ctrl.masterEnable) begin
          if (r.txHeld) begin
            takeTx  = 1'b1;
            n.state = r.ctrl.i2sMode ? SSM_I2SM1 : SSM_MSTART;
          end
        end else if (r.ctrl.i2sMode) begin
          if (r.ssF != r.ssPrev) begin
            takeTx  = 1'b1;
            n.state = SSM_I2SS1;
          end
        end else if (ssAsserted) begin
          n.state = SSM_SWAIT;
        end
      end
      SSM_SWAIT: begin
        if (!ssAsserted) begin
          n.state = SSM_IDLE;
        end else if (sckRise) begin
          takeTx    = 1'b1;
          n.state   = SSM_SHIFT;
          n.bitIdx  = firstBit(r.ctrl.charLength);
          n.phaseTx = 1'b0;
        end
      end
      SSM_I2SS1:  if (sckRise) n.state = SSM_I2SS2;
      SSM_I2SM1:  if (sckRise) n.state = SSM_I2SM2;
      SSM_I2SS2, SSM_MSTART, SSM_I2SM2: begin
        if (sckRise) begin
          n.state   = SSM_SHIFT;
          n.bitIdx  = firstBit(r.ctrl.charLength);
          n.phaseTx = 1'b0;
        end
      end
      SSM_SHIFT: begin
        if (!r.phaseTx) begin
          if (sckFall) n.phaseTx = 1'b1;
        end else if (r.bitIdx != 3'h0) begin
          if (sckRise) begin
            n.bitIdx  = r.bitIdx - 3'h1;
            n.phaseTx = 1'b0;
          end
        end else if (sckRise | (!r.ctrl.masterEnable & !ssAsserted)) begin
          // last bit done: a select release here is a clean end
          evRxLoad = 1'b1;
          n.state  = SSM_IDLE;
          if (!r.ctrl.masterEnable & !r.ctrl.i2sMode & ssAsserted) begin
            takeTx    = 1'b1;
            n.state   = SSM_SHIFT;
            n.bitIdx  = firstBit(r.ctrl.charLength);
            n.phaseTx = 1'b0;
          end
        end
        if (!r.ctrl.masterEnable & !r.ctrl.i2sMode & !ssAsserted &
            !(r.phaseTx & (r.bitIdx == 3'h0))) begin
          evAbort = 1'b1;
          n.state = SSM_IDLE;
        end
      end
      default: n.state = SSM_IDLE;
    endcase

    // mode fault: another master pulls our select while we master
    if (r.ctrl.masterEnable & !r.ctrl.selectIsOutput & ssAsserted &
        (r.ssF != r.ssPrev)) begin
      evCollision = 1'b1;
      n.state     = SSM_IDLE;
    end
    if (sckTimeout & !r.ctrl.masterEnable & r.ctrl.rateGenControl) begin
      evAbort = 1'b1;
      n.state = SSM_IDLE;
    end

    // -------------------------------------------------------------
    // holding register flags; set beats clear in the same cycle
    // -------------------------------------------------------------
    evUnderrun = takeTx & !r.txHeld & !r.ctrl.masterEnable;
    evOverrun  = evRxLoad & r.rxFull & !rxDataRead;
    if (takeTx) n.txHeld = 1'b0;
    if (txDataWrite) n.txHeld = 1'b1;
    if (rxDataRead) n.rxFull = 1'b0;
    if (evRxLoad) n.rxFull = 1'b1;
    if (wrCommit & hitStatus) begin
      if (pwdata[ST_UNDERRUN]) n.underrun = 1'b0;
      if (pwdata[ST_COLLIDE]) n.collision = 1'b0;
      if (pwdata[ST_ABORT]) n.abort = 1'b0;
      if (pwdata[ST_OVERRUN]) n.overrun = 1'b0;
    end
    n.underrun  = n.underrun | evUnderrun;
    n.collision = n.collision | evCollision;
    n.abort     = n.abort | evAbort;
    n.overrun   = n.overrun | evOverrun;

    // -------------------------------------------------------------
    // disabled port: state, holding and status flags return to reset; irq status and enable keep their values
    // -------------------------------------------------------------
    if (!r.ctrl.portEnable) begin
      n.state     = SSM_IDLE;
      n.txHeld    = 1'b0;
      n.rxFull    = 1'b0;
      n.underrun  = 1'b0;
      n.collision = 1'b0;
      n.abort     = 1'b0;
      n.overrun   = 1'b0;
      evUnderrun  = 1'b0;
      evCollision = 1'b0;
      evAbort     = 1'b0;
      evOverrun   = 1'b0;
      evRxLoad    = 1'b0;
      takeTx      = 1'b0;
    end
    n.txEmptyFlag    = r.ctrl.portEnable & !n.txHeld;
    n.transferActive = (n.state != SSM_IDLE) &&
                       (n.state != SSM_SWAIT);
    n.selectLevel    = r.ctrl.portEnable ?
                       (r.ssF ^ r.ctrl.selectPolarity) :
                       STATUS_RST[ST_SELECT];
    n.clockPinLevel  = r.sckF;
    n.dataInLevel    = r.ctrl.masterEnable ? r.misoF : r.mosiF;
    n.stateCode      = codeOf(n.state, n.bitIdx, n.phaseTx);

    // -------------------------------------------------------------
    // interrupt: sticky events, enable mask, write-one clear
    // -------------------------------------------------------------
    events = '0;
    events[IRQ_UNDERRUN] = evUnderrun;
    events[IRQ_COLLIDE]  = evCollision;
    events[IRQ_ABORT]    = evAbort;
    events[IRQ_OVERRUN]  = evOverrun;
    events[IRQ_RX_LOAD]  = evRxLoad;
    events[IRQ_TX_TAKEN] = takeTx;
    if (wrCommit & hitIrqClr) n.irqStatus = r.irqStatus & ~pwdata[IRQ_W-1:0];
    n.irqStatus = n.irqStatus | events;
    n.irq       = |(n.irqStatus & n.irqEnable);

    if (sys_rst) begin
      n             = '0;
      n.ssSh        = 3'h7;
      n.ssF         = 1'b1;
      n.ssPrev      = 1'b1;
      n.selectLevel = STATUS_RST[ST_SELECT];
      n.stateCode   = STATE_RST[5:0];
      n.state       = SSM_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    r <= n;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_disable_status: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !r.ctrl.portEnable |=> statusWord == STATUS_RST)
    else $error("status not at reset while disabled");

  chk_txempty_write: assert property (
    @(posedge mclk) disable iff (sys_rst)
    txDataWrite |=> !r.txEmptyFlag)
    else $error("tx empty flag not cleared by tx data write");

  chk_w1c_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    wrCommit && hitStatus && pwdata[ST_OVERRUN] && !evOverrun
    |=> !r.overrun)
    else $error("overrun flag not cleared by write of one");

  chk_underrun_hold: assert property (
    @(posedge mclk) disable iff (sys_rst)
    r.underrun && r.ctrl.portEnable &&
    !(wrCommit && hitStatus && pwdata[ST_UNDERRUN]) |=> r.underrun)
    else $error("underrun flag dropped without a clear");

  chk_collision_set: assert property (
    @(posedge mclk) disable iff (sys_rst)
    evCollision |=> r.collision && r.state == SSM_IDLE)
    else $error("collision not flagged");

  chk_abort_select: assert property (
    @(posedge mclk) disable iff (sys_rst)
    r.ctrl.portEnable && r.state == SSM_SHIFT && !r.ctrl.masterEnable &&
    !r.ctrl.i2sMode && !ssAsserted && !(r.phaseTx & ~|r.bitIdx) |=> r.abort)
    else $error("slave abort missed on early select release");

  chk_abort_timeout: assert property (
    @(posedge mclk) disable iff (sys_rst)
    r.ctrl.portEnable && sckTimeout && !r.ctrl.masterEnable &&
    r.ctrl.rateGenControl |=> r.abort)
    else $error("slave abort missed on clock time-out");

  chk_rxfull_read: assert property (
    @(posedge mclk) disable iff (sys_rst)
    rxDataRead && !evRxLoad |=> !r.rxFull)
    else $error("rx full not cleared by read");

  chk_clock_track: assert property (
    @(posedge mclk) disable iff (sys_rst)
    sckPin [*5] |=> r.clockPinLevel)
    else $error("clock pin level not reflected");

  chk_irq_level: assert property (
    @(posedge mclk) disable iff (sys_rst)
    r.irq == |(r.irqStatus & r.irqEnable))
    else $error("interrupt output disagrees with status and enable");

endmodule // ssm_top

// [dv/ssm_far_end.sv]
// far-end spi master model that drives the port's pins
`timescale 1ns/1ps
module ssm_far_end (
  output logic sckPin,  // serial clock, still between frames
  output logic mosiPin, // data into the port
  output logic misoPin, // data from another slave
  output logic ssPin    // slave select, active low
);
  initial begin
    sckPin = 1'b0;
    mosiPin = 1'b0;
    misoPin = 1'b0;
    ssPin = 1'b1;
  end
  task automatic sel(input logic v);
    ssPin <= v;
    // a released line must not keep showing the last bit
    if (v) mosiPin <= ~mosiPin;
  endtask
  task automatic clk(input logic v);
    sckPin <= v;
  endtask
  task automatic dat(input logic d, input logic q);
    mosiPin <= d;
    misoPin <= q;
  endtask
  // 64 ns link clock offset from mclk; fewer than 8 bits cuts the character
  task automatic frame(input int nBits);
    #1 sel(1'b0);
    #64;
    for (int i = 0; i < nBits; i++) begin
      mosiPin <= i[0];
      sckPin <= 1'b1;
      #32 sckPin <= 1'b0;
      #32;
    end
    sel(1'b1);
    #64;
  endtask
endmodule // ssm_far_end

// [dv/ssm_top_tb.sv]
// self-checking bench of the status and state monitor
`timescale 1ns/1ps
module ssm_top_tb;
  import ssm_pkg::*;
  localparam logic [31:0] A_ST = {6'h00, IDX_STATUS, 2'b00};
  localparam logic [31:0] A_SE = {6'h00, IDX_STATE, 2'b00};
  localparam logic [31:0] A_CT = {6'h00, IDX_CTRL, 2'b00};
  localparam logic [31:0] A_IS = {6'h00, IDX_IRQ_STAT, 2'b00};
  localparam logic [31:0] A_IE = {6'h00, IDX_IRQ_EN, 2'b00};
  localparam logic [31:0] A_IC = {6'h00, IDX_IRQ_CLR, 2'b00};
  logic        mclk, sysRst, psel, penable, pwrite, pready, pslverr, irq;
  logic [31:0] paddr, pwdata, prdata, rdv;
  logic        sckPin, mosiPin, misoPin, ssPin, errv;
  logic        txDataWrite, rxDataRead, sckTimeout;
  int          errors, nChecks;
  ssm_top dut (.mclk(mclk), .sys_rst(sysRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sckPin(sckPin),
    .mosiPin(mosiPin), .misoPin(misoPin), .ssPin(ssPin),
    .txDataWrite(txDataWrite), .rxDataRead(rxDataRead),
    .sckTimeout(sckTimeout), .irq(irq));
  ssm_far_end far (.sckPin(sckPin), .mosiPin(mosiPin), .misoPin(misoPin),
    .ssPin(ssPin));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // --------------------
  // tasks
  // --------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until pready is sampled high, released after that edge
  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      report_and_stop();
    end
    @(posedge mclk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string what, input logic [31:0] a,
                    input logic [31:0] exp, input logic [31:0] m = '1);
    apb(1'b0, a, 32'h0);
    chk(what, rdv & m, exp);
  endtask
  task automatic strobe(input int k);
    txDataWrite <= (k == 0);
    rxDataRead  <= (k == 1);
    sckTimeout  <= (k == 2);
    @(posedge mclk);
    {txDataWrite, rxDataRead, sckTimeout} <= 3'h0;
    @(posedge mclk);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // --------------------
  // tests
  // --------------------
  initial begin
    {psel, penable, pwrite, txDataWrite, rxDataRead, sckTimeout} = '0;
    paddr = '0;
    pwdata = '0;
    sysRst = 1'b1;
    errors = 0;
    nChecks = 0;
    repeat (6) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    rd("status reset", A_ST, 32'h01);
    wr(A_SE, 32'hFF);
    rd("state read only", A_SE, 32'h00);
    apb(1'b0, 32'h0, 32'h0);
    chk("unmapped", {rdv[30:0], errv}, 32'h01);
    wr(A_ST, 32'hFF);
    rd("status disabled", A_ST, 32'h01);
    $display("test reset done");
    wr(A_CT, 32'h01);
    rd("tx empty", A_ST, 32'h81);
    strobe(0);
    rd("tx held", A_ST, 32'h01);
    far.sel(1'b0);
    waitc(8);
    rd("wait code", A_SE, 32'h01, 32'h3F);
    for (int i = 7; i >= 0; i--) begin
      far.clk(1'b1);
      waitc(8);
      rd("rx code", A_SE, {26'h0, 2'b10, 3'(i), 1'b0}, 32'h3F);
      far.clk(1'b0);
      waitc(8);
      rd("tx code", A_SE, {26'h0, 2'b10, 3'(i), 1'b1}, 32'h3F);
    end
    rd("active", A_ST, 32'h82);
    far.sel(1'b1);
    waitc(8);
    rd("char done", A_ST, 32'h85);
    far.frame(8);
    waitc(6);
    rd("under over", A_ST, 32'hCD);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(A_ST, 32'h00);
    rd("write zero", A_ST, 32'hCD);
    wr(A_ST, 32'h48);
    rd("write one", A_ST, 32'h85);
    strobe(1);
    rd("rx read", A_ST, 32'h81);
    wr(A_IC, 32'h3F);
    rd("irq cleared", A_IS, 32'h00);
    $display("test slave character done");
    strobe(0);
    far.frame(3);
    waitc(6);
    rd("abort", A_ST, 32'h91);
    wr(A_CT, 32'h00);
    rd("disable", A_ST, 32'h01);
    wr(A_CT, 32'h01);
    strobe(2);
    rd("no rate gen", A_ST, 32'h81);
    wr(A_CT, 32'h09);
    strobe(2);
    rd("timeout", A_ST, 32'h91);
    wr(A_ST, 32'h10);
    wr(A_CT, 32'h05);
    waitc(8);
    rd("pol high", A_ST, 32'h00, 32'h01);
    far.sel(1'b0);
    waitc(8);
    rd("pol low", A_ST, 32'h01, 32'h01);
    far.sel(1'b1);
    $display("test abort and polarity done");
    wr(A_CT, 32'h00);
    wr(A_IE, 32'h02);
    wr(A_CT, 32'h03);
    strobe(0);
    waitc(2);
    rd("master start", A_SE, 32'h10, 32'h3F);
    far.sel(1'b0);
    waitc(8);
    rd("collision", A_ST, 32'hA0);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rd("irq status", A_IS, 32'h26);
    wr(A_IC, 32'h02);
    waitc(2);
    chk("irq dropped", {31'h0, irq}, 32'h0);
    far.sel(1'b1);
    wr(A_ST, 32'h20);
    waitc(8);
    rd("collision clear", A_ST, 32'h81);
    $display("test collision done");
    // sck and data-in follow the synchronised pins in both roles
    for (int k = 0; k < 8; k++) begin
      wr(A_CT, {30'h0, k[2], 1'b1});
      far.dat(k[0], k[1]);
      far.clk(k[0] ^ k[1]);
      waitc(8);
      rd("pins", A_SE, {24'h0, k[0] ^ k[1], k[2] ? k[1] : k[0], 6'h0},
         32'hC0);
    end
    $display("test pins done");
    // i2s slave with 3-bit characters: toggle start, one delay, short index
    wr(A_CT, 32'hD1);
    far.sel(1'b0);
    waitc(8);
    rd("i2s underrun", A_ST, 32'hC2);
    rd("i2s slave start", A_SE, 32'h02, 32'h3F);
    far.clk(1'b1);
    waitc(8);
    rd("i2s slave delay", A_SE, 32'h03, 32'h3F);
    far.clk(1'b0);
    waitc(8);
    far.clk(1'b1);
    waitc(8);
    rd("short char", A_SE, 32'h24, 32'h3F);
    wr(A_CT, 32'h00);
    wr(A_CT, 32'h13);
    strobe(0);
    rd("i2s master start", A_SE, 32'h31, 32'h3F);
    far.clk(1'b0);
    waitc(8);
    far.clk(1'b1);
    waitc(8);
    rd("i2s master delay", A_SE, 32'h32, 32'h3F);
    // a select driven by the port itself is no mode fault
    wr(A_CT, 32'h00);
    wr(A_CT, 32'h23);
    far.sel(1'b1);
    waitc(8);
    far.sel(1'b0);
    waitc(8);
    rd("select out", A_ST, 32'h80);
    rd("ctrl", A_CT, 32'h23);
    sysRst <= 1'b1;
    waitc(2);
    sysRst <= 1'b0;
    @(posedge mclk);
    rd("status mid reset", A_ST, 32'h01);
    rd("ctrl mid reset", A_CT, 32'h00);
    $display("test modes and reset done");
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    report_and_stop();
  end
endmodule // ssm_top_tb
